// File: rtl/tx_ser_pkg.sv
// Constants and carriers for the multi-lane transmit serializer.
// Assumes one 40 MHz system clock; link rates are enable pulses.
package tx_ser_pkg;
    localparam int NUM_LANES = 4;
    localparam int SER_FACTOR = 8;
    localparam int SER_FACTOR_MIN = 3;
    localparam int SER_FACTOR_MAX = 10;
    localparam int NUM_PHASES = 8;
    localparam int PHASE_STEP_DEG = 45;
    localparam int PHASE_W = 6;
    localparam int DIV_W = 5;
    localparam int BITCNT_W = 4;
    localparam logic [PHASE_W-1:0] PHASE_RESET = 6'h00;
    localparam logic [DIV_W-1:0] DIV_RESET = 5'h08;
    localparam logic [BITCNT_W-1:0] FACTOR_RESET = 4'h8;

    typedef struct packed {
        logic fclk_en;
        logic loaden;
        logic core_clk;
        logic [NUM_PHASES-1:0] vco_phase;
        logic pll_locked;
        logic fclk_shift_en;
        logic loaden_shift;
    } pll_clocks_t;

    typedef struct packed {
        logic align_on;
        logic [BITCNT_W-1:0] factor;
        logic [PHASE_W-1:0] phase_sel;
        logic [DIV_W-1:0] out_div;
    } tx_config_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WAIT = 2'b01,
        ST_RUN = 2'b11
    } ser_state_t;
endpackage

// File: rtl/lane_shifter.sv
// One serial lane: parallel load on the load pulse, MSB-first shift.
// Assumes load and shift enables are single-cycle pulses of clk_in.
`timescale 1ns/1ps
module lane_shifter
    import tx_ser_pkg::*;
#(
    parameter int WIDTH = SER_FACTOR_MAX
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic load_in,
    input wire logic shift_in,
    input wire logic [BITCNT_W-1:0] factor_in,
    input wire logic [WIDTH-1:0] word_in,
    output logic bit_out
);
    logic [WIDTH-1:0] sh_reg;
    logic [WIDTH-1:0] sh_next;

    always_comb begin
        sh_next = sh_reg;
        if (load_in) begin
            // Left-justify so the word MSB leaves first
            sh_next = word_in << (WIDTH - int'(factor_in));
        end else if (shift_in) begin
            sh_next = {sh_reg[WIDTH-2:0], 1'b0};
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            sh_reg <= '0;
        end else begin
            sh_reg <= sh_next;
        end
    end

    assign bit_out = sh_reg[WIDTH-1];
endmodule

// File: rtl/tx_serializer.sv
// Multi-lane transmit serializer with forwarded clock and core clock select.
// Assumes an external PLL supplies the fast, load and core rates as enables.
`timescale 1ns/1ps
module tx_serializer
    import tx_ser_pkg::*;
#(
    parameter int LANES = NUM_LANES,
    parameter int WMAX = SER_FACTOR_MAX
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire pll_clocks_t pll_in,
    input wire tx_config_t cfg_in,
    input wire logic [LANES*WMAX-1:0] word_in,
    output logic [LANES-1:0] lanes_out,
    output logic fwd_clk_out,
    output logic core_clk_out,
    output logic word_taken_out,
    output logic cfg_error_out
);
    function automatic logic factor_ok(input logic [BITCNT_W-1:0] f);
        return (f >= BITCNT_W'(SER_FACTOR_MIN)) && (f <= BITCNT_W'(SER_FACTOR_MAX));
    endfunction

    ser_state_t st_reg, st_next;
    logic [BITCNT_W-1:0] bit_reg, bit_next;
    logic [8:0] ph_reg, ph_next;
    logic [DIV_W-1:0] div_reg, div_next;
    logic fwd_reg, fwd_next;
    logic core_reg, core_next;
    logic taken_reg, taken_next;
    logic err_reg, err_next;
    logic [LANES-1:0] lane_bits;
    logic load_go, shift_go, align_ok, delayed_edge;
    logic [2:0] sub_phase;
    logic [PHASE_W-4:0] bit_offset;

    // Alignment needs the VCO phases and lock from the PLL
    assign align_ok = cfg_in.align_on & pll_in.pll_locked & (|pll_in.vco_phase);
    assign load_go = pll_in.loaden & (st_reg != ST_IDLE) & factor_ok(cfg_in.factor);
    assign shift_go = pll_in.fclk_en & (st_reg == ST_RUN) & ~load_go;
    // Phase split into whole bits and 45 degree eighths
    assign sub_phase = cfg_in.phase_sel[2:0];
    assign bit_offset = cfg_in.phase_sel[PHASE_W-1:3];
    // Shifted fast copy marks the sub-bit edge off 180 multiples
    assign delayed_edge = (sub_phase[1:0] == 2'b00) ? pll_in.fclk_en : pll_in.fclk_shift_en;

    genvar g;
    generate
        for (g = 0; g < LANES; g++) begin : g_lane
            lane_shifter #(.WIDTH(WMAX)) u_lane (
                .clk_in(clk_in),
                .rst_in(rst_in),
                .load_in(load_go),
                .shift_in(shift_go),
                .factor_in(cfg_in.factor),
                .word_in(word_in[g*WMAX +: WMAX]),
                .bit_out(lane_bits[g])
            );
        end
    endgenerate

    always_comb begin
        st_next = st_reg;
        bit_next = bit_reg;
        ph_next = ph_reg;
        div_next = div_reg;
        fwd_next = fwd_reg;
        taken_next = 1'b0;
        err_next = ~factor_ok(cfg_in.factor);
        case (st_reg)
            ST_IDLE: st_next = ST_WAIT;
            ST_WAIT: if (load_go) st_next = ST_RUN;
            ST_RUN: if (err_next) st_next = ST_WAIT;
            default: st_next = ST_IDLE;
        endcase
        if (load_go) begin
            // Word boundary: forwarded clock edge lands on MSB only when bit_offset is zero and sub_phase is below 4
            bit_next = '0;
            div_next = '0;
            taken_next = 1'b1;
            fwd_next = (bit_offset == '0) && (sub_phase < 3'h4);
        end else if (shift_go) begin
            bit_next = bit_reg + BITCNT_W'(1);
            if (div_reg + DIV_W'(1) >= cfg_in.out_div) begin
                div_next = '0;
            end else begin
                div_next = div_reg + DIV_W'(1);
            end
            // High for the first half of each divided period, or the second half on a delayed edge with nonzero bit_offset
            fwd_next = ({1'b0, div_next} < {1'b0, cfg_in.out_div >> 1})
                ^ ((bit_offset != '0) && delayed_edge);
        end
        ph_next = {ph_reg[7:0], load_go};
        // Core clock source select
        core_next = align_ok ? pll_in.loaden : pll_in.core_clk;
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            st_reg <= ST_IDLE;
            bit_reg <= '0;
            ph_reg <= '0;
            div_reg <= '0;
            fwd_reg <= 1'b0;
            core_reg <= 1'b0;
            taken_reg <= 1'b0;
            err_reg <= 1'b0;
            lanes_out <= '0;
        end else begin
            st_reg <= st_next;
            bit_reg <= bit_next;
            ph_reg <= ph_next;
            div_reg <= div_next;
            fwd_reg <= fwd_next;
            core_reg <= core_next;
            taken_reg <= taken_next;
            err_reg <= err_next;
            lanes_out <= lane_bits;
        end
    end

    assign fwd_clk_out = fwd_reg;
    assign core_clk_out = core_reg;
    assign word_taken_out = taken_reg;
    assign cfg_error_out = err_reg;

    chk_core_pass: assert property (@(posedge clk_in) disable iff (rst_in)
        !(cfg_in.align_on) |=> core_clk_out == $past(pll_in.core_clk))
        else $error("core clock not passed through");
    chk_core_align: assert property (@(posedge clk_in) disable iff (rst_in)
        align_ok |=> core_clk_out == $past(pll_in.loaden))
        else $error("aligned core clock not from load pulse");
    chk_load_taken: assert property (@(posedge clk_in) disable iff (rst_in)
        load_go |=> word_taken_out)
        else $error("load not acknowledged");
    chk_bad_factor: assert property (@(posedge clk_in) disable iff (rst_in)
        !factor_ok(cfg_in.factor) |=> cfg_error_out)
        else $error("bad factor not flagged");
    chk_no_bad_load: assert property (@(posedge clk_in) disable iff (rst_in)
        cfg_error_out |-> !word_taken_out)
        else $error("load with bad factor");
    chk_msb_first: assert property (@(posedge clk_in) disable iff (rst_in)
        load_go && factor_ok(cfg_in.factor) |=> ##1
        lanes_out[0] == $past(word_in[int'(cfg_in.factor)-1], 2))
        else $error("lane 0 did not start with MSB");
    chk_zero_edge: assert property (@(posedge clk_in) disable iff (rst_in)
        load_go && cfg_in.phase_sel == '0 |=> fwd_clk_out)
        else $error("forwarded edge not on MSB");
    chk_reset_idle: assert property (@(posedge clk_in)
        rst_in |=> st_reg == ST_IDLE && lanes_out == '0 && !fwd_clk_out)
        else $error("reset did not clear state");
    cov_load: cover property (@(posedge clk_in) disable iff (rst_in) load_go ##[1:20] load_go);
    cov_align: cover property (@(posedge clk_in) disable iff (rst_in) align_ok && load_go);
    cov_err: cover property (@(posedge clk_in) disable iff (rst_in) cfg_error_out);
endmodule

// File: sim/pll_model.sv
// Clock source model: fast, load, core and phase enables for the serializer.
// Assumes one clk_in domain and a synchronous active high reset.
`timescale 1ns/1ps
module pll_model
    import tx_ser_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [BITCNT_W-1:0] factor_in,
    output pll_clocks_t pll_out
);
    logic [1:0] ph_reg = 2'h1;
    logic [1:0] ph_next;
    logic [3:0] cnt_reg = 4'h1;
    logic [3:0] cnt_next;
    logic [7:0] tick_reg = 8'h00;
    logic [7:0] tick_next;
    always_comb begin
        ph_next = (ph_reg == 2'h2) ? 2'h0 : ph_reg + 2'h1;
        cnt_next = cnt_reg;
        if (ph_reg == 2'h0) begin
            cnt_next = (cnt_reg + 4'h1 >= factor_in) ? 4'h0 : cnt_reg + 4'h1;
        end
        tick_next = tick_reg + 8'h01;
    end
    always_ff @(posedge clk_in) begin
        ph_reg <= rst_in ? 2'h1 : ph_next;
        cnt_reg <= rst_in ? 4'h1 : cnt_next;
        tick_reg <= rst_in ? 8'h00 : tick_next;
    end
    always_comb begin
        pll_out.fclk_en = (ph_reg == 2'h0);
        pll_out.loaden = (ph_reg == 2'h0) && (cnt_reg == 4'h0);
        pll_out.core_clk = tick_reg[0];
        pll_out.vco_phase = 8'h01 << tick_reg[2:0];
        pll_out.pll_locked = ~rst_in;
        pll_out.fclk_shift_en = pll_out.fclk_en;
        pll_out.loaden_shift = pll_out.loaden;
    end
endmodule

// File: sim/tx_serializer_tb.sv
// Self-checking bench for the transmit serializer.
// Assumes the clock source model drives the rate enables.
`timescale 1ns/1ps
module tx_serializer_tb
    import tx_ser_pkg::*;
;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    pll_clocks_t pll;
    tx_config_t cfg = '{1'b0, FACTOR_RESET, PHASE_RESET, DIV_RESET};
    logic [39:0] word = 40'h0;
    logic [3:0] lanes;
    logic fwd, core, taken, cerr;
    int err_total = 0;
    int check_count = 0;
    int cycles = 0;
    always #12.5 clk_in = ~clk_in;
    pll_model pll_src (.clk_in(clk_in), .rst_in(rst_in), .factor_in(cfg.factor), .pll_out(pll));
    tx_serializer uut (.clk_in(clk_in), .rst_in(rst_in), .pll_in(pll), .cfg_in(cfg),
        .word_in(word), .lanes_out(lanes), .fwd_clk_out(fwd), .core_clk_out(core),
        .word_taken_out(taken), .cfg_error_out(cerr));
    task automatic stop_test();
        if (err_total == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [3:0] e, input logic [3:0] g);
        check_count++;
        if (g !== e) begin
            err_total++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wait_load();
        for (int i = 0; i < 200; i++) begin
            @(posedge clk_in);
            #1;
            if (pll.loaden === 1'b1) return;
        end
        err_total++;
        stop_test();
    endtask
    // One word, then every bit of every lane
    task automatic send(input logic [3:0] f, input logic [39:0] w);
        logic [3:0] e;
        @(posedge clk_in);
        cfg.factor <= f;
        cfg.out_div <= {1'b0, f};
        word <= w;
        wait_load();
        @(posedge clk_in);
        #1;
        chk("taken", 4'h1, {3'h0, taken});
        chk("fwd", 4'h1, {3'h0, fwd});
        for (int i = 0; i < f; i++) begin
            repeat ((i == 0) ? 1 : 3) @(posedge clk_in);
            #1;
            for (int g = 0; g < 4; g++) e[g] = w[g*10 + f - 1 - i];
            chk("lanes", e, lanes);
        end
        chk("fwd", 4'h0, {3'h0, fwd});
    endtask
    task automatic bad_factor(input logic [3:0] f);
        @(posedge clk_in);
        cfg.factor <= f;
        wait_load();
        @(posedge clk_in);
        #1;
        chk("cfg_err", 4'h1, {3'h0, cerr});
        chk("taken", 4'h0, {3'h0, taken});
    endtask
    task automatic core_check(input logic on);
        logic s;
        @(posedge clk_in);
        cfg.align_on <= on;
        repeat (2) @(posedge clk_in);
        #1;
        for (int i = 0; i < 30; i++) begin
            s = on ? pll.loaden : pll.core_clk;
            @(posedge clk_in);
            #1;
            chk("core", {3'h0, s}, {3'h0, core});
        end
    endtask
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            stop_test();
        end
    end
    initial begin
        repeat (16) @(posedge clk_in);
        rst_in <= 1'b0;
        send(4'h8, 40'h96_a5c3_3d2b);
        send(4'h3, 40'h5a_3c0f_f1e7);
        send(4'ha, 40'hc3_5aa5_0ff0);
        bad_factor(4'h2);
        bad_factor(4'hb);
        send(4'h8, 40'h3c_96a5_5a69);
        core_check(1'b0);
        core_check(1'b1);
        @(posedge clk_in);
        rst_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        #1;
        chk("rst_lanes", 4'h0, lanes);
        chk("rst_outs", 4'h0, {fwd, core, taken, cerr});
        @(posedge clk_in);
        rst_in <= 1'b0;
        send(4'h8, 40'ha5_0ff0_c33c);
        stop_test();
    end
endmodule
